// ---- rpc_regs.vh ----
// Constants for the receiver polling controller.
// Assumes inclusion by the design file and the bench; definitions only.
`ifndef RPC_REGS_VH
`define RPC_REGS_VH

// Register indices on the plain register port
`define RPC_ADDR_OPERATING_CONFIG_REGISTER 4'h0
`define RPC_ADDR_LIMIT 4'h1
`define RPC_ADDR_STATUS 4'h2

// Operating config field positions
`define RPC_NAP_LSB 0
`define RPC_NAP_MSB 4
`define RPC_BAUD_LSB 5
`define RPC_BAUD_MSB 6
`define RPC_XPERM_BIT 7
`define RPC_XTEMP_BIT 8
`define RPC_NBIT_LSB 9
`define RPC_NBIT_MSB 10

// Limit register field positions
`define RPC_LMIN_LSB 0
`define RPC_LMIN_MSB 5
`define RPC_LMAX_LSB 6
`define RPC_LMAX_MSB 11

// Reset values
`define RPC_OPERATING_CONFIG_REGISTER_RST 12'h04a
`define RPC_LIMIT_RST 12'h60e

// Timing counts
`define RPC_NAP_UNIT 16'h0400
`define RPC_XSLEEP_EXT 4'h8
`define RPC_XSLEEP_STD 4'h1
`define RPC_DIV_LOW 4'ha
`define RPC_DIV_HIGH 4'he
`define RPC_STARTUP_BASE 12'h0c0
`endif

// ---- rpc_poll_ctrl.v ----
// Polling controller: sleep, start-up and bit check cycle with data hand-over.
// Assumes clk is the crystal oscillator clock; all inputs are synchronous to it.
//
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "rpc_regs.vh"

module rpc_poll_ctrl #(
   parameter DIV_W = 4,
   parameter NAP_UNIT = 1024
) (
   input wire clk,
   input wire rst_n,
   input wire ce,
   input wire div_select,
   input wire host_enable,
   input wire demod_in,
   input wire data_line_in,
   output wire data_line_out,
   output wire data_line_oe_n,
   output reg data_out,
   output wire path_power,
   output wire rx_active,
   input wire [3:0] reg_addr,
   input wire [11:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [11:0] reg_rdata
);

   ////////////////////////////////////////////////////////////////////
   // Behaviour notes
   //
   // Phases in order: sleep, start-up, bit check, then sleep again
   // Receive only entered from a bit check that met its count
   // Receive left only when the host drops its enable line
   // Host enable low overrides every phase, not just sleep
   // Sleep count restarts once enable comes back high
   //
   // Timing base:
   // Crystal clock divided by ten or fourteen, strap selected
   // One base tick per divided period, one clock wide
   // Every phase timer counts base ticks, never raw clocks
   // First sleep tick may be partial; divider is free running
   // Partial tick costs at most one base period of sleep
   // Restarting the divider per phase was judged not worth it
   //
   // Sleep length:
   // Count field times extension factor times the unit
   // Unit is a parameter so benches can shrink it
   // Count at its top value parks the block in sleep
   // Zero count leaves sleep on the very next clock
   //
   // Extension:
   // Permanent bit stretches every sleep, host owned
   // Temporary bit stretches sleep until a check fails
   // Failed check clears the temporary bit in hardware
   // Host write in the same cycle loses to that clear
   //
   // Bit check:
   // Band clock is one, two, four or eight base ticks
   // Band prescaler restarts on each entry to the check
   // Edge counter restarts at every accepted edge
   // Early edge below the lower limit ends the check
   // Counter reaching the upper limit ends the check too
   // Zero checks configured means receive right away
   //
   // Host link:
   // Data line released high outside receive
   // Drive value is a registered copy of the demodulator
   // Line input kept for the two-way pin, not decoded here
   //
   // Register port:
   // Writes land on the edge that samples the strobe
   // Reads return data one cycle later, zero otherwise
   // Unmapped addresses read zero and ignore writes
   //
   // Clock enable low freezes every flip-flop in the block

   ////////////////////////////////////////////////////////////////////
   // Functions

   // Extension factor from the two extension bits
   function [3:0] xsleep;
      input perm;
      input temp;
      begin
         xsleep = (perm | temp) ? `RPC_XSLEEP_EXT : `RPC_XSLEEP_STD;
      end
   endfunction

   // Edge checks needed: twice the bit count of 0,3,6,9
   function [4:0] check_count;
      input [1:0] nsel;
      begin
         case (nsel)
            2'h0: check_count = 5'h00;
            2'h1: check_count = 5'h06;
            2'h2: check_count = 5'h0c;
            default: check_count = 5'h12;
         endcase
      end
   endfunction

   ////////////////////////////////////////////////////////////////////
   // State encoding, one-hot

   localparam [3:0] ST_SLEEP = 4'h1;
   localparam [3:0] ST_START = 4'h2;
   localparam [3:0] ST_CHECK = 4'h4;
   localparam [3:0] ST_RECV = 4'h8;

   ////////////////////////////////////////////////////////////////////
   // Registers and signals

   reg [11:0] operating_config_register_reg; // Operating config register
   reg [11:0] operating_config_register_next;
   reg [11:0] limit_reg; // Bit check window limits
   reg [3:0] state_reg; // Polling phase
   reg [3:0] state_next;
   reg [DIV_W-1:0] div_reg; // Crystal to base clock divider
   reg base_tick_reg; // One pulse per base clock period
   reg [3:0] xclk_reg; // Band clock prescaler
   reg [19:0] timer_reg; // Phase timer in base ticks
   reg [19:0] timer_next;
   reg [5:0] cv_reg; // Edge-to-edge counter in band ticks
   reg [5:0] cv_next;
   reg [4:0] checks_reg; // Passed edge checks
   reg [4:0] checks_next;
   reg demod_q_reg; // Previous demodulator level for edges
   reg clr_temp; // Hardware clear of temporary extension
   reg sleep_hold_reg; // Host enable was low, sleep restarts
   wire [4:0] nap_cnt; // Sleep count field
   wire [1:0] baud_band_select; // Baud band field
   wire [3:0] div_max; // Terminal count of divider
   wire [3:0] xclk_max; // Band clock terminal count
   wire xclk_tick; // One pulse per band clock period
   wire demod_edge; // Edge on demodulator output
   wire [19:0] sleep_len; // Sleep length in base ticks
   wire [19:0] start_len; // Start-up length in base ticks
   wire [5:0] lim_min;
   wire [5:0] lim_max;

   assign nap_cnt = operating_config_register_reg[`RPC_NAP_MSB:`RPC_NAP_LSB];
   assign baud_band_select = operating_config_register_reg[`RPC_BAUD_MSB:`RPC_BAUD_LSB];
   assign lim_min = limit_reg[`RPC_LMIN_MSB:`RPC_LMIN_LSB];
   assign lim_max = limit_reg[`RPC_LMAX_MSB:`RPC_LMAX_LSB];

   // Pin level picks the division factor; a static strap in practice
   assign div_max = div_select ? (`RPC_DIV_HIGH - 4'h1) : (`RPC_DIV_LOW - 4'h1);

   // Sleep length: count x factor x unit
   // Every operand sized to the 20-bit result on purpose
   assign sleep_len = {15'h0000, nap_cnt}
      * {16'h0000, xsleep(operating_config_register_reg[`RPC_XPERM_BIT], operating_config_register_reg[`RPC_XTEMP_BIT])}
      * NAP_UNIT[19:0];

   // Start-up shortens as the band select rises
   assign start_len = {8'h00, (`RPC_STARTUP_BASE >> baud_band_select)};

   // Band clock: 1, 2, 4 or 8 base periods
   assign xclk_max = (4'h1 << baud_band_select) - 4'h1;
   assign xclk_tick = base_tick_reg && (xclk_reg == xclk_max);
   assign demod_edge = demod_in ^ demod_q_reg;

   // Power and host link outputs
   assign path_power = (state_reg != ST_SLEEP);
   assign rx_active = (state_reg == ST_RECV);
   // One line serves both directions; released (high) until data is live
   assign data_line_out = data_out;
   assign data_line_oe_n = ~rx_active;

   ////////////////////////////////////////////////////////////////////
   // Base clock divider

   // All phase timing counts base ticks only
   // Divider never stops, so phase timers see a steady tick rate
   // Tick is registered to keep it glitch free for the timers
   // Prescaler held at zero outside the check phase
   always @(posedge clk) begin
      if (!rst_n) begin
         div_reg <= {DIV_W{1'b0}};
         base_tick_reg <= 1'b0;
         xclk_reg <= 4'h0;
      end else if (ce) begin
         base_tick_reg <= (div_reg == div_max[DIV_W-1:0]);
         if (div_reg == div_max[DIV_W-1:0]) begin
            div_reg <= {DIV_W{1'b0}};
         end else begin
            div_reg <= div_reg + {{(DIV_W-1){1'b0}}, 1'b1};
         end
         // Band prescaler restarts with each check
         if (state_reg != ST_CHECK) begin
            xclk_reg <= 4'h0;
         end else if (base_tick_reg) begin
            xclk_reg <= (xclk_reg == xclk_max) ? 4'h0 : xclk_reg + 4'h1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Polling state machine

   // Next phase, timer and check counters
   // Timer cleared on every phase change so each phase starts fresh
   // Edge judged before band tick: an edge on a tick counts as edge
   // Enable low checked last so it wins over every other branch
   always @* begin
      state_next = state_reg;
      timer_next = timer_reg;
      cv_next = cv_reg;
      checks_next = checks_reg;
      clr_temp = 1'b0;
      case (state_reg)
         ST_SLEEP: begin
            // Hold while enable low or count at its top value
            if (!host_enable || sleep_hold_reg || (nap_cnt == 5'h1f)) begin
               timer_next = 20'h00000;
            end else if (base_tick_reg) begin
               if (timer_reg + 20'h00001 >= sleep_len) begin
                  state_next = ST_START;
                  timer_next = 20'h00000;
               end else begin
                  timer_next = timer_reg + 20'h00001;
               end
            end else if (sleep_len == 20'h00000) begin
               state_next = ST_START;
            end
         end
         ST_START: begin
            // Let the path settle before judging edges
            if (base_tick_reg) begin
               if (timer_reg + 20'h00001 >= start_len) begin
                  state_next = ST_CHECK;
                  timer_next = 20'h00000;
                  cv_next = 6'h00;
                  checks_next = 5'h00;
               end else begin
                  timer_next = timer_reg + 20'h00001;
               end
            end
         end
         ST_CHECK: begin
            if (checks_reg >= check_count(operating_config_register_reg[`RPC_NBIT_MSB:`RPC_NBIT_LSB])) begin
               state_next = ST_RECV;
            end else if (demod_edge) begin
               if (cv_reg < lim_min) begin
                  state_next = ST_SLEEP;
                  clr_temp = 1'b1;
               end else begin
                  checks_next = checks_reg + 5'h01;
                  cv_next = 6'h00;
               end
            end else if (xclk_tick) begin
               if (cv_reg + 6'h01 >= lim_max) begin
                  state_next = ST_SLEEP;
                  clr_temp = 1'b1;
               end else begin
                  cv_next = cv_reg + 6'h01;
               end
            end
            if (state_next == ST_SLEEP) begin
               timer_next = 20'h00000;
            end
         end
         ST_RECV: begin
            // Leave reception only by host enable
            if (!host_enable) begin
               state_next = ST_SLEEP;
               timer_next = 20'h00000;
            end
         end
         default: begin
            state_next = ST_SLEEP;
            timer_next = 20'h00000;
         end
      endcase
      // Enable low overrides every phase
      if (!host_enable) begin
         state_next = ST_SLEEP;
         timer_next = 20'h00000;
      end
   end

   // Config register update, write and hardware clear
   // Clear applied after the write so hardware wins the race
   // Other bits of a same-cycle write still land
   always @* begin
      operating_config_register_next = operating_config_register_reg;
      if (reg_wr && reg_addr == `RPC_ADDR_OPERATING_CONFIG_REGISTER) begin
         operating_config_register_next = reg_wdata;
      end
      // Host write of the bit in the same cycle still loses to the clear
      if (clr_temp) begin
         operating_config_register_next[`RPC_XTEMP_BIT] = 1'b0;
      end
   end

   always @(posedge clk) begin
      if (!rst_n) begin
         state_reg <= ST_SLEEP;
         timer_reg <= 20'h00000;
         cv_reg <= 6'h00;
         checks_reg <= 5'h00;
         demod_q_reg <= 1'b0;
         operating_config_register_reg <= `RPC_OPERATING_CONFIG_REGISTER_RST;
         limit_reg <= `RPC_LIMIT_RST;
         sleep_hold_reg <= 1'b0;
         data_out <= 1'b1;
      end else if (ce) begin
         state_reg <= state_next;
         timer_reg <= timer_next;
         cv_reg <= cv_next;
         checks_reg <= checks_next;
         demod_q_reg <= demod_in;
         operating_config_register_reg <= operating_config_register_next;
         if (reg_wr && reg_addr == `RPC_ADDR_LIMIT) begin
            limit_reg <= reg_wdata;
         end
         // Enable low restarts the sleep count on release
         sleep_hold_reg <= !host_enable;
         // Data released high unless receiving
         data_out <= (state_next == ST_RECV) ? demod_in : 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Register read port

   // Read data valid the cycle after the strobe only
   // Zero outside that cycle so a stale word is never seen
   // Status word shows check count and one-hot phase
   always @(posedge clk) begin
      if (!rst_n) begin
         reg_rdata <= 12'h000;
      end else if (ce) begin
         if (reg_rd) begin
            case (reg_addr)
               `RPC_ADDR_OPERATING_CONFIG_REGISTER: reg_rdata <= operating_config_register_reg;
               `RPC_ADDR_LIMIT: reg_rdata <= limit_reg;
               `RPC_ADDR_STATUS: reg_rdata <= {3'h0, checks_reg, state_reg};
               default: reg_rdata <= 12'h000;
            endcase
         end else begin
            reg_rdata <= 12'h000;
         end
      end
   end

endmodule

// ---- rpc_host_model.sv ----
// Host stand-in: owns the enable line, listens on the shared data line.
// Assumes a pull-up on the data line and one clock for all parties.
`timescale 1ns/1ps
module rpc_host_model (
   input wire clk,
   input wire enable_req,
   input wire line_drive,
   input wire line_oe_n,
   output reg host_enable,
   output wire line_level
);
   ////////////////////////////////
   // Enable comes from a port flop, one cycle behind the request
   initial host_enable = 1'b1;
   always @(posedge clk) begin
      host_enable <= enable_req;
   end
   // Host never drives, so a released line floats up to the pull-up level
   assign line_level = line_oe_n ? 1'b1 : line_drive;
endmodule

// ---- rpc_poll_ctrl_props.sv ----
// Port checker for the polling controller.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ps
module rpc_poll_props (
   input wire clk,
   input wire rst_n,
   input wire host_enable,
   input wire demod_in,
   input wire data_line_out,
   input wire data_line_oe_n,
   input wire data_out,
   input wire path_power,
   input wire rx_active,
   input wire reg_rd,
   input wire [11:0] reg_rdata
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   ////////////////////////////////
   property p_oe_rx;
      data_line_oe_n == !rx_active;
   endproperty
   a_oe_rx: assert property (p_oe_rx) else $error("line enable wrong");
   property p_line_drv;
      data_line_out == data_out;
   endproperty
   a_line_drv: assert property (p_line_drv) else $error("line drive wrong");
   property p_rx_pwr;
      rx_active |-> path_power;
   endproperty
   a_rx_pwr: assert property (p_rx_pwr) else $error("receive without power");
   // Data only leaves the device while receiving
   property p_idle_high;
      !rx_active && !$past(rx_active) |-> data_out;
   endproperty
   a_idle_high: assert property (p_idle_high) else $error("data moved when idle");
   property p_rx_data;
      rx_active && $past(rx_active) |-> data_out == $past(demod_in);
   endproperty
   a_rx_data: assert property (p_rx_data) else $error("data not passed");
   property p_en_sleep;
      !host_enable |=> !path_power && !rx_active;
   endproperty
   a_en_sleep: assert property (p_en_sleep) else $error("awake with enable low");
   property p_rx_hold;
      rx_active && host_enable |=> rx_active;
   endproperty
   a_rx_hold: assert property (p_rx_hold) else $error("receive dropped");
   property p_rx_entry;
      $rose(rx_active) |-> $past(path_power);
   endproperty
   a_rx_entry: assert property (p_rx_entry) else $error("receive from sleep");
   // Start-up settling is far longer than eight cycles
   property p_startup;
      disable iff (!rst_n || !host_enable) $rose(path_power) |-> path_power[*8];
   endproperty
   a_startup: assert property (p_startup) else $error("start-up cut short");
   property p_rdata_idle;
      !$past(reg_rd) |-> reg_rdata == 12'h000;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data stale");
endmodule
bind rpc_poll_ctrl rpc_poll_props chk_u (.clk(clk), .rst_n(rst_n), .host_enable(host_enable),
   .demod_in(demod_in), .data_line_out(data_line_out), .data_line_oe_n(data_line_oe_n),
   .data_out(data_out), .path_power(path_power), .rx_active(rx_active), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata));

// ---- rpc_poll_ctrl_tb.sv ----
// Self-checking bench for the polling controller.
// Assumes NAP_UNIT of 4 and the host stand-in on enable and data lines.
`timescale 1ns/1ps
`include "rpc_regs.vh"
module rpc_poll_ctrl_tb;
   reg clk = 1'b0;
   reg rst_n = 1'b0;
   reg div_select = 1'b0;
   reg en_req = 1'b1;
   reg demod_in = 1'b0;
   reg [3:0] reg_addr = 4'h0;
   reg [11:0] reg_wdata = 12'h000;
   reg reg_wr = 1'b0;
   reg reg_rd = 1'b0;
   reg pp_q = 1'b0;
   wire [11:0] reg_rdata;
   wire data_line_out, data_line_oe_n, data_out, path_power, rx_active, host_enable, data_line_in;
   integer n_errors = 0, compares = 0, cyc = 0, hp = 0, falls = 0, i, c, e, prev;
   rpc_poll_ctrl #(.NAP_UNIT(4)) dut_u (.clk(clk), .rst_n(rst_n), .ce(1'b1),
      .div_select(div_select), .host_enable(host_enable), .demod_in(demod_in),
      .data_line_in(data_line_in), .data_line_out(data_line_out),
      .data_line_oe_n(data_line_oe_n), .data_out(data_out), .path_power(path_power),
      .rx_active(rx_active), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata));
   rpc_host_model host_u (.clk(clk), .enable_req(en_req), .line_drive(data_line_out),
      .line_oe_n(data_line_oe_n), .host_enable(host_enable), .line_level(data_line_in));
   ////////////////////////////////
   always #2.5 clk = ~clk;
   // Hang guard, well above the roughly 35k cycles the run needs
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (cyc >= 100000) begin
         n_errors = n_errors + 1;
         stop_test;
      end
   end
   // Transmitter stand-in: long steady preburst toggling every hp cycles
   always begin
      @(posedge clk);
      if (hp > 0) begin
         repeat (hp - 1) @(posedge clk);
         demod_in <= ~demod_in;
      end
   end
   // Count returns to sleep
   always @(negedge clk) begin
      pp_q <= path_power;
      if (pp_q && !path_power) falls = falls + 1;
   end
   ////////////////////////////////
   task chk(input [127:0] what, input [11:0] seen, input [11:0] exp);
      begin
         compares = compares + 1;
         if (seen !== exp) begin
            n_errors = n_errors + 1;
            $display("wrong value %0s expected %h seen %h", what, exp, seen);
         end
      end
   endtask
   task wr(input [3:0] a, input [11:0] d);
      begin
         reg_addr <= a;
         reg_wdata <= d;
         reg_wr <= 1'b1;
         @(posedge clk);
         reg_wr <= 1'b0;
         @(posedge clk);
      end
   endtask
   task rdc(input [3:0] a, input [11:0] exp, input [127:0] what);
      begin
         reg_addr <= a;
         reg_rd <= 1'b1;
         @(posedge clk);
         reg_rd <= 1'b0;
         #1 chk(what, reg_rdata, exp);
         @(posedge clk);
      end
   endtask
   task reset_dut;
      begin
         rst_n <= 1'b0;
         repeat (16) @(posedge clk);
         rst_n <= 1'b1;
         @(posedge clk);
      end
   endtask
   // Cycles until the path powers up, capped at 9000
   task wait_pp(output integer n);
      begin
         n = 0;
         while (path_power !== 1'b1 && n < 9000) begin
            @(negedge clk);
            n = n + 1;
         end
         @(posedge clk);
      end
   endtask
   // Enable low pulse restarts the sleep; count from its rising edge
   task nap_len(output integer n);
      begin
         en_req <= 1'b0;
         @(posedge clk);
         en_req <= 1'b1;
         repeat (3) @(negedge clk);
         wait_pp(n);
         n = n + 3;
      end
   endtask
   // Band 3, three-bit check, given count and extension bits
   function [11:0] om(input [4:0] nap, input perm, input temp);
      om = {3'h1, temp, perm, 2'h3, nap};
   endfunction
   function [11:0] win(input integer n, input integer x);
      // First base tick may be partial: allow ten cycles short, one period at divide-by-ten
      win = (n >= x - 10 && n <= x + 6) ? 12'h001 : 12'h000;
   endfunction
   task stop_test;
      begin
         if (n_errors == 0 && compares > 0) $display("ALL TESTS PASSED");
         else $display("TESTS FAILED");
         $finish;
      end
   endtask
   ////////////////////////////////
   initial begin
      reset_dut;
      rdc(`RPC_ADDR_OPERATING_CONFIG_REGISTER, `RPC_OPERATING_CONFIG_REGISTER_RST, "operating_config_register");
      rdc(`RPC_ADDR_LIMIT, `RPC_LIMIT_RST, "limit");
      wr(4'h3, 12'hfff);
      rdc(4'h3, 12'h000, "unmapped");
      // Sleep length over strap, extension and count
      for (i = 0; i < 4; i = i + 1) begin
         div_select <= (i == 1);
         reset_dut;
         wr(`RPC_ADDR_OPERATING_CONFIG_REGISTER, om((i == 3) ? 5'h03 : 5'h01, i == 2, 1'b0));
         nap_len(c);
         e = ((i == 3) ? 3 : 1) * ((i == 2) ? 8 : 1) * 4 * ((i == 1) ? 14 : 10);
         chk("sleep", win(c, e), 12'h001);
      end
      div_select <= 1'b0;
      reset_dut;
      wr(`RPC_ADDR_OPERATING_CONFIG_REGISTER, om(5'h01, 1'b0, 1'b1));
      nap_len(c);
      chk("temp sleep", win(c, 320), 12'h001);
      repeat (2500) @(posedge clk);
      rdc(`RPC_ADDR_OPERATING_CONFIG_REGISTER, om(5'h01, 1'b0, 1'b0), "temp clear");
      nap_len(c);
      chk("plain sleep", win(c, 40), 12'h001);
      wr(`RPC_ADDR_OPERATING_CONFIG_REGISTER, om(5'h1f, 1'b0, 1'b0));
      nap_len(c);
      chk("hold", (c >= 9000) ? 12'h001 : 12'h000, 12'h001);
      wr(`RPC_ADDR_OPERATING_CONFIG_REGISTER, om(5'h01, 1'b0, 1'b0));
      wait_pp(c);
      chk("wake", (c < 100) ? 12'h001 : 12'h000, 12'h001);
      // Valid preburst inside the default window reaches receive
      reset_dut;
      wr(`RPC_ADDR_OPERATING_CONFIG_REGISTER, om(5'h01, 1'b0, 1'b0));
      hp = 1440;
      c = 0;
      while (rx_active !== 1'b1 && c < 30000) begin
         @(negedge clk);
         c = c + 1;
      end
      chk("receive", rx_active, 12'h001);
      hp = 0;
      repeat (12) begin
         @(posedge clk);
         demod_in <= ~demod_in;
         @(negedge clk);
         prev = demod_in;
         @(negedge clk);
         chk("data", data_line_in, prev);
      end
      @(posedge clk);
      en_req <= 1'b0;
      hp = 0;
      repeat (4) @(negedge clk);
      chk("off", {rx_active, path_power, data_line_in}, 12'h001);
      @(posedge clk);
      en_req <= 1'b1;
      // Edges far too close: never receives, keeps polling
      reset_dut;
      wr(`RPC_ADDR_OPERATING_CONFIG_REGISTER, om(5'h01, 1'b0, 1'b0));
      hp = 160;
      falls = 0;
      repeat (12000) @(negedge clk);
      chk("noise", {rx_active, falls > 2}, 12'h001);
      hp = 0;
      stop_test;
   end
endmodule
